// >>> flc_host.sv
// Purpose: Sequences lock, OTP and write-buffer commands to a flash.
// Assumes: Status reads are single reads; CTRL picks x8 or x16.
// Notes:   Software orders over APB and polls STATUS.
// Behaviour
// - Unlock only when engine idle, not suspended
// - Unlock is setup then confirm, poll ready
// - After aborted unlock, host repeats unlock; this host sets the STATUS error flag and stops instead
// - Secure lock first write C0h anywhere
// - Second write at 8Ch, active-low select bits
// - 90h enters ID mode, FFh returns
// - OTP program: C0h then address/data write
// - Program FFFDh at lock word locks user
// - Byte mode decodes A8..A0, upper zero
// - E8h to block, read XSR availability
// - Count N means N+1 units
// - Data in block, then D0h confirm
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module flc_host (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Flash pins
    output logic      [23:0] fl_addr_o,
    output logic      [15:0] fl_dq_o,
    output logic             fl_dq_oe_o,
    input  wire logic [15:0] fl_dq_i,
    output logic             fl_ce_n_o,
    output logic             fl_oe_n_o,
    output logic             fl_we_n_o,
    output logic             fl_byte_n_o,
    input  wire logic        fl_busy_status_pin_i
);
    typedef struct packed {
        flc_pkg::flc_state_t st;
        logic [3:0]  op;
        logic [1:0]  step;
        logic [3:0]  tmr;
        logic        byte_mode;
        logic        busy;
        logic        done;
        logic        host_err;
        logic [23:0] addr;
        logic [15:0] data;
        logic [23:0] blk;
        logic [15:0] rdata;
        logic [5:0]  buf_left;
        logic [23:0] a_o;
        logic [15:0] dq_o;
        logic        oe_dq;
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic [1:0]  sync_dq_v;
        logic [15:0] dq_s1;
        logic [15:0] dq_s2;
        logic [1:0]  sts_s;
    } flc_regs_t;

    flc_regs_t s_q;
    flc_regs_t s_d;

    // Protection register address check
    function automatic logic otp_addr_ok(input logic [23:0] a, input logic bm);
        logic [8:0] off;
        off = a[8:0] - flc_pkg::OTP_BASE_ADDR[8:0];
        if (a[23:9] != 15'h0000 || !a[8])
            return 1'b0;
        if (bm)
            return off[8:0] <= 9'h011;
        return off[8:1] <= 8'h08;
    endfunction

    // Factory half of the protection register
    function automatic logic otp_is_factory(input logic [23:0] a, input logic bm);
        if (bm)
            return a[7:0] >= 8'h02 && a[7:0] <= 8'h09;
        return a[7:1] >= 7'h01 && a[7:1] <= 7'h04;
    endfunction

    // Orders sent as a setup write and a second write
    function automatic logic is_pair(input logic [3:0] o);
        return o == flc_pkg::OP_UNLOCK || o == flc_pkg::OP_SECURE ||
               o == flc_pkg::OP_OTP_PROG || o == flc_pkg::OP_OTP_LOCK;
    endfunction

    logic apb_acc;
    assign apb_acc = psel_i && penable_i && !s_q.pready;

    always_comb begin
        s_d = s_q;
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        // Pins of an unclocked device
        s_d.dq_s1 = fl_dq_i;
        s_d.dq_s2 = s_q.dq_s1;
        s_d.sts_s = {s_q.sts_s[0], fl_busy_status_pin_i};
        if (s_q.tmr != 4'h0)
            s_d.tmr = s_q.tmr - 4'h1;

        if (apb_acc) begin
            s_d.pready = 1'b1;
            if (pwrite_i) begin
                case (paddr_i)
                    flc_pkg::REG_ADDR: s_d.addr = pwdata_i[23:0];
                    flc_pkg::REG_DATA: s_d.data = pwdata_i[15:0];
                    flc_pkg::REG_CTRL: begin
                        // Refused while busy: keeps a sequence whole
                        if (s_q.busy) begin
                            s_d.pslverr = 1'b1;
                        end else begin
                            // Done is sticky so a slow poll cannot miss it
                            s_d.done = 1'b0;
                            s_d.op = pwdata_i[3:0];
                            s_d.byte_mode = pwdata_i[8];
                            s_d.busy = 1'b1;
                            s_d.host_err = 1'b0;
                            s_d.step = 2'h0;
                            s_d.st = flc_pkg::ST_WR_LOW;
                        end
                    end
                    default: s_d.pslverr = 1'b1;
                endcase
            end else begin
                case (paddr_i)
                    flc_pkg::REG_CTRL:   s_d.prdata = {23'h0, s_q.byte_mode, 4'h0, s_q.op};
                    flc_pkg::REG_ADDR:   s_d.prdata = {8'h00, s_q.addr};
                    flc_pkg::REG_DATA:   s_d.prdata = {16'h0000, s_q.data};
                    flc_pkg::REG_STATUS: s_d.prdata = {28'h0, s_q.sts_s[1], s_q.host_err,
                                                       s_q.done, s_q.busy};
                    flc_pkg::REG_RDATA:  s_d.prdata = {16'h0000, s_q.rdata};
                    flc_pkg::REG_BUF:    s_d.prdata = {26'h0, s_q.buf_left};
                    default: begin
                        s_d.prdata = 32'h0000_0000;
                        s_d.pslverr = 1'b1;
                    end
                endcase
            end
        end

        case (s_q.st)
            flc_pkg::ST_IDLE: begin
                s_d.ce_n = 1'b1;
                s_d.oe_n = 1'b1;
                s_d.we_n = 1'b1;
                s_d.oe_dq = 1'b0;
            end
            flc_pkg::ST_WR_LOW: begin
                // Address and data of this bus cycle
                s_d.a_o = s_q.addr;
                s_d.dq_o = {8'h00, flc_pkg::CMD_READ_STATUS};
                s_d.st = flc_pkg::ST_WR_HIGH;
                case (s_q.op)
                    flc_pkg::OP_UNLOCK:
                        s_d.dq_o = {8'h00, (s_q.step == 2'h0) ? flc_pkg::CMD_UNLOCK_SETUP
                                                               : flc_pkg::CMD_CONFIRM};
                    flc_pkg::OP_SECURE: begin
                        s_d.dq_o = (s_q.step == 2'h0) ? {8'h00, flc_pkg::CMD_SECURE_LOCK}
                                                      : {11'h000, s_q.data[4:0]};
                        if (s_q.step != 2'h0)
                            s_d.a_o = flc_pkg::SECURE_LOCK_ADDR;
                    end
                    flc_pkg::OP_OTP_PROG, flc_pkg::OP_OTP_LOCK: begin
                        s_d.dq_o = (s_q.step == 2'h0) ? {8'h00, flc_pkg::CMD_OTP_SETUP}
                                 : (s_q.op == flc_pkg::OP_OTP_LOCK) ? flc_pkg::OTP_LOCK_USER
                                 : s_q.data;
                        if (s_q.op == flc_pkg::OP_OTP_LOCK)
                            s_d.a_o = flc_pkg::OTP_BASE_ADDR;
                        // Bad OTP targets are stopped here rather than left to the device
                        if (s_q.op == flc_pkg::OP_OTP_PROG &&
                            (!otp_addr_ok(s_q.addr, s_q.byte_mode) ||
                             otp_is_factory(s_q.addr, s_q.byte_mode))) begin
                            s_d.host_err = 1'b1;
                            s_d.st = flc_pkg::ST_DONE;
                        end
                    end
                    flc_pkg::OP_READ_ID:  s_d.dq_o = {8'h00, flc_pkg::CMD_READ_ID};
                    flc_pkg::OP_READ_ARR: s_d.dq_o = {8'h00, flc_pkg::CMD_READ_ARRAY};
                    flc_pkg::OP_CLR_STAT: s_d.dq_o = {8'h00, flc_pkg::CMD_CLEAR_STATUS};
                    flc_pkg::OP_BUF_OPEN: begin
                        s_d.blk = s_q.addr;
                        s_d.dq_o = {8'h00, flc_pkg::CMD_BUF_WRITE};
                        if (s_q.step != 2'h0) begin
                            // Count taken from DATA[4:0], clipped to the buffer size
                            s_d.dq_o = {11'h000, s_q.byte_mode ?
                                (s_q.data[4:0] > flc_pkg::BUF_MAX_BYTE ? flc_pkg::BUF_MAX_BYTE
                                                                       : s_q.data[4:0]) :
                                (s_q.data[4:0] > flc_pkg::BUF_MAX_WORD ? flc_pkg::BUF_MAX_WORD
                                                                       : s_q.data[4:0])};
                            s_d.a_o = s_q.blk;
                            s_d.buf_left = {1'b0, s_d.dq_o[4:0]} + 6'h01;
                        end
                    end
                    flc_pkg::OP_BUF_DATA: begin
                        s_d.dq_o = s_q.data;
                        if (s_q.addr[23:17] != s_q.blk[23:17] || s_q.buf_left == 6'h00) begin
                            s_d.host_err = 1'b1;
                            s_d.st = flc_pkg::ST_DONE;
                        end
                    end
                    flc_pkg::OP_BUF_CONF: begin
                        s_d.dq_o = {8'h00, flc_pkg::CMD_CONFIRM};
                        s_d.a_o = s_q.blk;
                    end
                    flc_pkg::OP_WRITE: s_d.dq_o = s_q.data;
                    flc_pkg::OP_RD_STAT, flc_pkg::OP_READ: ;
                    default: begin
                        s_d.host_err = 1'b1;
                        s_d.st = flc_pkg::ST_DONE;
                    end
                endcase
                if (s_q.op == flc_pkg::OP_READ) begin
                    s_d.st = flc_pkg::ST_RD_LOW;
                    s_d.oe_dq = 1'b0;
                    s_d.tmr = flc_pkg::T_RD;
                end else if (s_d.st == flc_pkg::ST_WR_HIGH) begin
                    s_d.ce_n = 1'b0;
                    s_d.we_n = 1'b0;
                    s_d.oe_dq = 1'b1;
                    s_d.tmr = flc_pkg::T_WE_LOW;
                end
            end
            flc_pkg::ST_WR_HIGH: begin
                if (s_q.tmr == 4'h0 && !s_q.we_n) begin
                    s_d.we_n = 1'b1;
                    s_d.tmr = flc_pkg::T_WE_HIGH;
                end else if (s_q.tmr == 4'h0) begin
                    s_d.ce_n = 1'b1;
                    s_d.oe_dq = 1'b0;
                    s_d.step = s_q.step + 2'h1;
                    if (s_q.op == flc_pkg::OP_BUF_DATA)
                        s_d.buf_left = s_q.buf_left - 6'h01;
                    if (is_pair(s_q.op) && s_q.step == 2'h0)
                        s_d.st = flc_pkg::ST_WR_LOW; // Second write of the pair
                    else if (s_q.op == flc_pkg::OP_BUF_OPEN && s_q.step == 2'h0) begin
                        s_d.st = flc_pkg::ST_RD_LOW;
                        s_d.tmr = flc_pkg::T_RD;
                    end else if (s_q.op == flc_pkg::OP_BUF_OPEN) begin
                        s_d.st = flc_pkg::ST_DONE;
                    end else if (is_pair(s_q.op) || s_q.op == flc_pkg::OP_BUF_CONF) begin
                        s_d.st = flc_pkg::ST_POLL;
                    end else if (s_q.op == flc_pkg::OP_RD_STAT) begin
                        s_d.st = flc_pkg::ST_RD_LOW;
                        s_d.tmr = flc_pkg::T_RD;
                    end else begin
                        s_d.st = flc_pkg::ST_DONE;
                    end
                end
            end
            flc_pkg::ST_RD_LOW: begin
                s_d.ce_n = 1'b0;
                s_d.oe_n = 1'b0;
                // Three extra cycles let the data synchroniser settle
                if (s_q.tmr == 4'h0 && s_q.sync_dq_v == 2'h3) begin
                    s_d.rdata = s_q.dq_s2;
                    s_d.ce_n = 1'b1;
                    s_d.oe_n = 1'b1;
                    s_d.sync_dq_v = 2'h0;
                    if (s_q.op == flc_pkg::OP_BUF_OPEN)
                        s_d.st = flc_pkg::ST_WR_LOW; // Back to a write: E8h again if XSR shows busy, else the count
                    else if (s_q.op == flc_pkg::OP_RD_STAT || s_q.op == flc_pkg::OP_READ)
                        s_d.st = flc_pkg::ST_DONE;
                    else if (!s_q.dq_s2[flc_pkg::SR_READY])
                        s_d.st = flc_pkg::ST_RD_LOW;
                    else begin
                        // Device error flags
                        s_d.host_err = s_q.dq_s2[flc_pkg::SR_UNLOCK] | s_q.dq_s2[flc_pkg::SR_PROG] |
                                       s_q.dq_s2[flc_pkg::SR_VOLT] | s_q.dq_s2[flc_pkg::SR_LOCK];
                        s_d.st = flc_pkg::ST_DONE;
                    end
                    if (s_q.op == flc_pkg::OP_BUF_OPEN)
                        s_d.step = {1'b0, s_q.dq_s2[flc_pkg::XSR_AVAIL]};
                    s_d.tmr = flc_pkg::T_RD;
                end else if (s_q.tmr == 4'h0) begin
                    s_d.sync_dq_v = s_q.sync_dq_v + 2'h1;
                end
            end
            flc_pkg::ST_POLL: begin
                s_d.st = flc_pkg::ST_RD_LOW;
                s_d.tmr = flc_pkg::T_RD;
            end
            flc_pkg::ST_DONE: begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
                s_d.st = flc_pkg::ST_IDLE;
            end
            default: s_d.st = flc_pkg::ST_IDLE;
        endcase
        if (reset_i) begin
            s_d = '0;
            s_d.st = flc_pkg::ST_IDLE;
            s_d.ce_n = 1'b1;
            s_d.oe_n = 1'b1;
            s_d.we_n = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        s_q <= s_d;
    end

    assign prdata_o    = s_q.prdata;
    assign pready_o    = s_q.pready;
    assign pslverr_o   = s_q.pslverr;
    assign fl_addr_o   = s_q.a_o;
    assign fl_dq_o     = s_q.dq_o;
    assign fl_dq_oe_o  = s_q.oe_dq;
    assign fl_ce_n_o   = s_q.ce_n;
    assign fl_oe_n_o   = s_q.oe_n;
    assign fl_we_n_o   = s_q.we_n;
    assign fl_byte_n_o = !s_q.byte_mode;
endmodule // flc_host

// >>> flc_pkg.sv
// Purpose: Constants and types of the flash command host.
// Assumes: Asynchronous flash, x16 data, 24 address lines.
// Notes:   Command codes and protection register map.
package flc_pkg;
    // =========================================================
    // Flash command codes, lock addresses and OTP lock word
    localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
    localparam logic [7:0] CMD_READ_ID      = 8'h90;
    localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_UNLOCK_SETUP = 8'h60;
    localparam logic [7:0] CMD_CONFIRM      = 8'hD0;
    localparam logic [7:0] CMD_SECURE_LOCK  = 8'hC0;
    localparam logic [7:0] CMD_OTP_SETUP    = 8'hC0;
    localparam logic [7:0] CMD_BUF_WRITE    = 8'hE8;
    localparam logic [23:0] SECURE_LOCK_ADDR = 24'h00008C;
    localparam logic [15:0] OTP_LOCK_USER   = 16'hFFFD;
    localparam logic [23:0] OTP_BASE_ADDR   = 24'h000100;
    // =========================================================
    // Status bit positions and buffer count limits
    localparam int SR_READY  = 7;
    localparam int SR_UNLOCK = 5;
    localparam int SR_PROG   = 4;
    localparam int SR_VOLT   = 3;
    localparam int SR_LOCK   = 1;
    localparam int XSR_AVAIL = 7;
    localparam logic [4:0] BUF_MAX_BYTE = 5'h1F;
    localparam logic [4:0] BUF_MAX_WORD = 5'h0F;
    // =========================================================
    // Bus timing in clk_i cycles
    localparam logic [3:0] T_WE_LOW   = 4'h2;
    localparam logic [3:0] T_WE_HIGH  = 4'h2;
    localparam logic [3:0] T_RD       = 4'h3;
    // =========================================================
    // APB register map, byte addresses
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_DATA   = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_RDATA  = 8'h10;
    localparam logic [7:0] REG_BUF    = 8'h14;
    // Operation codes written to CTRL[3:0]
    localparam logic [3:0] OP_UNLOCK   = 4'h1;
    localparam logic [3:0] OP_SECURE   = 4'h2;
    localparam logic [3:0] OP_OTP_PROG = 4'h3;
    localparam logic [3:0] OP_OTP_LOCK = 4'h4;
    localparam logic [3:0] OP_READ_ID  = 4'h5;
    localparam logic [3:0] OP_READ_ARR = 4'h6;
    localparam logic [3:0] OP_BUF_OPEN = 4'h7;
    localparam logic [3:0] OP_BUF_DATA = 4'h8;
    localparam logic [3:0] OP_BUF_CONF = 4'h9;
    localparam logic [3:0] OP_RD_STAT  = 4'hA;
    localparam logic [3:0] OP_CLR_STAT = 4'hB;
    localparam logic [3:0] OP_WRITE    = 4'hC;
    localparam logic [3:0] OP_READ     = 4'hD;

    typedef enum logic [3:0] {
        ST_IDLE, ST_WR_LOW, ST_WR_HIGH, ST_RD_LOW, ST_POLL, ST_DONE
    } flc_state_t;
endpackage

// >>> flc_host_asserts.sv
// Purpose: Bus and flash pin checks for flc_host.
// Assumes: One clock; reset_i synchronous, active high.
// Notes:   Bound to every flc_host instance.
`timescale 1ns/1ps
module flc_host_chk (
    // Watched ports
    input wire logic        clk_i,
    input wire logic        reset_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic [7:0]  paddr_i,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic [23:0] fl_addr_o,
    input wire logic [15:0] fl_dq_o,
    input wire logic        fl_dq_oe_o,
    input wire logic        fl_ce_n_o,
    input wire logic        fl_oe_n_o,
    input wire logic        fl_we_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // =========================================================
    // Last byte written, to judge a write by its predecessor
    logic [7:0] last_q;
    always_ff @(posedge clk_i) begin
        if (reset_i) last_q <= 8'h00;
        else if (!fl_we_n_o) last_q <= fl_dq_o[7:0];
    end
    // =========================================================
    // Assertions
    ack_wait_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
        else $error("late pready");
    ack_pulse_a: assert property (pready_o |=> !pready_o)
        else $error("long pready");
    bad_addr_a: assert property (psel_i && penable_i && !pready_o && paddr_i > 8'h14 |=> pslverr_o)
        else $error("no pslverr");
    we_width_a: assert property ($fell(fl_we_n_o) |=> !fl_we_n_o [*2] ##1 fl_we_n_o)
        else $error("WE width");
    we_drive_a: assert property (!fl_we_n_o |-> fl_dq_oe_o && !fl_ce_n_o)
        else $error("WE undriven");
    we_hold_a: assert property (!fl_we_n_o && !$past(fl_we_n_o) |->
        $stable(fl_addr_o) && $stable(fl_dq_o))
        else $error("WE hold");
    rd_safe_a: assert property (!fl_oe_n_o |-> fl_we_n_o && !fl_dq_oe_o)
        else $error("read clash");
    confirm_a: assert property ($fell(fl_we_n_o) && last_q == 8'h60 |->
        fl_dq_o[7:0] == 8'hD0)
        else $error("no confirm");
    otp_upper_a: assert property ($fell(fl_we_n_o) && last_q == 8'hC0 && fl_addr_o[8] |->
        fl_addr_o[23:9] == 15'h0000)
        else $error("upper address set");
    cover property ($fell(fl_we_n_o) && last_q == 8'h60);
    cover property (pslverr_o);
    cover property ($fell(fl_oe_n_o));
endmodule // flc_host_chk
bind flc_host flc_host_chk flc_host_chk_i (.*);

// >>> flc_flash_model.sv
// Purpose: Behavioural flash: commands, status, locks, OTP, buffer.
// Assumes: A write commits when WE rises; the engine is always ready.
// Notes:   A released DQ shows the inverse of the last value driven.
`timescale 1ns/1ps
module flc_flash_model (
    // Host pins
    input  wire logic        clk_i,
    input  wire logic [23:0] addr_i,
    input  wire logic [15:0] dq_i,
    input  wire logic        ce_n_i,
    input  wire logic        oe_n_i,
    input  wire logic        we_n_i,
    input  wire logic        byte_n_i,
    // Supply state
    input  wire logic        vpen_low_i,
    output logic      [15:0] dq_o,
    output logic             busy_pin_o
);
    logic [7:0]  sr = 8'h80, pend = 8'h00, otp [16];
    logic [31:0] locks = 32'hFFFFFFFF, secure = 32'h0;
    logic [15:0] lockw = 16'hFFFE, val, last = 16'h0000, wd;
    logic [23:0] wa;
    logic [8:0]  bi, wb;
    logic [4:0]  cnt, blk;
    logic [1:0]  mode = 2'h0;
    logic        xok = 1'b0, lock_all = 1'b0, bad = 1'b0;
    // Factory bytes hold an arbitrary pattern
    initial for (int i = 0; i < 16; i++) otp[i] = (i < 8) ? 8'h3C : 8'hFF;
    assign busy_pin_o = 1'b1;
    assign bi = byte_n_i ? {addr_i[8:1], 1'b0} : addr_i[8:0];
    assign wb = byte_n_i ? {wa[8:1], 1'b0} : wa[8:0];
    always_comb begin
        case (mode)
            2'h1: val = {8'h00, sr};
            2'h2: val = (bi == 9'h100) ? lockw : (bi > 9'h101 && bi < 9'h112) ?
                {otp[bi - 9'h101], otp[bi - 9'h102]} : {15'h0, locks[addr_i[21:17]]};
            2'h3: val = {8'h00, xok, 7'h00};
            default: val = 16'hA5A5;
        endcase
    end
    assign dq_o = (!ce_n_i && !oe_n_i) ? val : ~last;
    always @(posedge clk_i) if (!ce_n_i && !oe_n_i) last <= val;
    // Capture while WE is low; address may move as WE rises
    always @(posedge clk_i) if (!we_n_i && !ce_n_i) begin wa <= addr_i; wd <= dq_i; end
    // First buffer poll sees it busy, forcing a retry
    always @(posedge oe_n_i) if (mode == 2'h3) xok = 1'b1;
    always @(posedge we_n_i) begin
        if (pend == 8'h60) begin
            pend = 8'h00;
            if (wd[7:0] != 8'hD0) sr = sr | 8'h30;
            else if (vpen_low_i) sr = sr | 8'h28;
            else locks = secure;
        end else if (pend == 8'hC0 && wa == 24'h00008C) begin
            pend = 8'h00;
            if (&wd[4:0]) sr = sr | 8'h30;
            secure = secure | {~wd[3], ~wd[2], 28'h0, ~wd[1], ~wd[0]} | {32{~wd[4]}};
            lock_all = lock_all | ~wd[4];
        end else if (pend == 8'hC0) begin
            pend = 8'h00;
            if (wa[23:9] != 15'h0 || wb < 9'h100 || wb == 9'h101 || wb > 9'h111) sr = sr | 8'h10;
            else if (wb == 9'h100) lockw = lockw & wd;
            else if (wb < 9'h10A ? !lockw[0] : !lockw[1]) sr = sr | 8'h12;
            else begin
                otp[wb - 9'h102] = otp[wb - 9'h102] & wd[7:0];
                if (byte_n_i) otp[wb - 9'h101] = otp[wb - 9'h101] & wd[15:8];
            end
        end else if (pend == 8'hE8 && xok) begin
            pend = 8'hE9; mode = 2'h1; cnt = wd[4:0]; blk = wa[21:17]; bad = 1'b0;
        end else if (pend == 8'hE9) begin
            bad = bad | (wa[21:17] != blk);
            if (cnt == 5'h00) pend = 8'hEA; else cnt = cnt - 5'h01;
        end else if (pend == 8'hEA) begin
            pend = 8'h00;
            if (bad || wd[7:0] != 8'hD0) sr = sr | 8'h30;
        end else case (wd[7:0])
            8'h60, 8'hC0: begin pend = wd[7:0]; mode = 2'h1; end
            8'hE8: begin if (mode != 2'h3) xok = 1'b0; pend = 8'hE8; mode = 2'h3; end
            8'h90: mode = 2'h2;
            8'hFF: mode = 2'h0;
            8'h70: mode = 2'h1;
            8'h50: sr = 8'h80;
            default: if (lock_all) sr = sr | 8'h12;
        endcase
    end
endmodule // flc_flash_model

// >>> tb_top.sv
// Purpose: Self-checking bench for flc_host.
// Assumes: APB master tasks; STATUS polling.
// Notes:   Expected values follow the command rules.
`timescale 1ns/1ps
module tb_top;
    logic        clk_i = 1'b0, reset_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0;
    logic        pwrite_i = 1'b0, vpen_low = 1'b0, bm = 1'b0, er, busy;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic [23:0] fl_addr_o;
    logic [15:0] fl_dq_o, mdq, fdq;
    logic        pready_o, pslverr_o, fl_dq_oe_o, fl_ce_n_o, fl_oe_n_o, fl_we_n_o, fl_byte_n_o;
    int          error_cnt = 0, cmp_count = 0;
    // Shared data bus
    assign fdq = fl_dq_oe_o ? fl_dq_o : mdq;
    always #50 clk_i = ~clk_i;
    flc_host flc_host_i (.clk_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .prdata_o, .pready_o, .pslverr_o, .fl_addr_o, .fl_dq_o, .fl_dq_oe_o, .fl_dq_i(fdq),
        .fl_ce_n_o, .fl_oe_n_o, .fl_we_n_o, .fl_byte_n_o, .fl_busy_status_pin_i(busy));
    flc_flash_model flc_flash_model_i (.clk_i, .addr_i(fl_addr_o), .dq_i(fdq),
        .ce_n_i(fl_ce_n_o), .oe_n_i(fl_oe_n_o), .we_n_i(fl_we_n_o), .byte_n_i(fl_byte_n_o),
        .vpen_low_i(vpen_low), .dq_o(mdq), .busy_pin_o(busy));
    // =========================================================
    // Tasks
    task automatic print_verdict();
        if (error_cnt == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk_i);
        psel_i <= 1'b1; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin @(posedge clk_i); n++; end while (pready_o !== 1'b1 && n < 50);
        if (n >= 50) begin error_cnt++; print_verdict(); end
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0; penable_i <= 1'b0;
    endtask
    task automatic wait_done();
        int n = 0;
        do begin apb(1'b0, flc_pkg::REG_STATUS, 32'h0); n++; end
        while (rd[1:0] !== 2'b10 && n < 300);
        if (n >= 300) begin error_cnt++; print_verdict(); end
    endtask
    // Error flag compared unless e is x
    task automatic op(input logic [23:0] a, input logic [15:0] d, input logic [3:0] o,
                      input logic e);
        apb(1'b1, flc_pkg::REG_ADDR, {8'h00, a});
        apb(1'b1, flc_pkg::REG_DATA, {16'h0000, d});
        apb(1'b1, flc_pkg::REG_CTRL, {23'h0, bm, 4'h0, o});
        wait_done();
        if (e !== 1'bx) chk({31'h0, rd[2]}, {31'h0, e});
    endtask
    task automatic rreg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        chk(rd & m, e);
    endtask
    task automatic idrd(input logic [23:0] a, input logic [31:0] e, m);
        op(a, 16'h0000, flc_pkg::OP_READ_ID, 1'bx);
        op(a, 16'h0000, flc_pkg::OP_READ, 1'bx);
        rreg(flc_pkg::REG_RDATA, e, m);
    endtask
    // =========================================================
    // Sequence
    initial begin
        repeat (20) @(posedge clk_i);
        reset_i <= 1'b0;
        rreg(flc_pkg::REG_STATUS, 32'h0, 32'hFFFFFFF7);
        rreg(8'h18, 32'h0, 32'hFFFFFFFF);
        chk({31'h0, er}, 32'h1);
        op(24'h000000, 16'h001E, flc_pkg::OP_SECURE, 1'b0);
        op(24'h000000, 16'h0000, flc_pkg::OP_UNLOCK, 1'b0);
        idrd(24'h000000, 32'h1, 32'h1);
        idrd(24'h020000, 32'h0, 32'h1);
        vpen_low <= 1'b1;
        op(24'h000000, 16'h0000, flc_pkg::OP_UNLOCK, 1'b1);
        op(24'h000000, 16'h0000, flc_pkg::OP_RD_STAT, 1'bx);
        rreg(flc_pkg::REG_RDATA, 32'h28, 32'h38);
        vpen_low <= 1'b0;
        op(24'h000000, 16'h0000, flc_pkg::OP_CLR_STAT, 1'bx);
        op(24'h000000, 16'h0000, flc_pkg::OP_UNLOCK, 1'b0);
        op(24'h000102, 16'h1111, flc_pkg::OP_OTP_PROG, 1'b1);
        op(24'h000200, 16'h1111, flc_pkg::OP_OTP_PROG, 1'b1);
        op(24'h00010A, 16'h1234, flc_pkg::OP_OTP_PROG, 1'b0);
        idrd(24'h00010B, 32'h1234, 32'hFFFF);
        bm <= 1'b1;
        op(24'h00010C, 16'h005A, flc_pkg::OP_OTP_PROG, 1'b0);
        idrd(24'h00010C, 32'h5A, 32'hFF);
        bm <= 1'b0;
        op(24'h000100, 16'hFFFD, flc_pkg::OP_OTP_LOCK, 1'b0);
        op(24'h00010E, 16'h0000, flc_pkg::OP_OTP_PROG, 1'b1);
        idrd(24'h000100, 32'hFFFC, 32'hFFFF);
        op(24'h000000, 16'h0000, flc_pkg::OP_CLR_STAT, 1'bx);
        op(24'h020000, 16'h0003, flc_pkg::OP_BUF_OPEN, 1'b0);
        rreg(flc_pkg::REG_BUF, 32'h4, 32'hFF);
        for (int i = 0; i < 4; i++) op(24'h020000 | i, 16'h0000, flc_pkg::OP_BUF_DATA, 1'bx);
        rreg(flc_pkg::REG_BUF, 32'h0, 32'hFF);
        op(24'h020000, 16'h0000, flc_pkg::OP_BUF_CONF, 1'b0);
        op(24'h020000, 16'h0000, flc_pkg::OP_BUF_OPEN, 1'b0);
        op(24'h020000, 16'h0000, flc_pkg::OP_BUF_DATA, 1'bx);
        op(24'h040000, 16'h0000, flc_pkg::OP_BUF_DATA, 1'b1);
        op(24'h020000, 16'h0000, flc_pkg::OP_BUF_CONF, 1'b0);
        apb(1'b1, flc_pkg::REG_CTRL, {28'h0, flc_pkg::OP_UNLOCK});
        apb(1'b1, flc_pkg::REG_CTRL, {28'h0, flc_pkg::OP_UNLOCK});
        chk({31'h0, er}, 32'h1);
        wait_done();
        op(24'h000000, 16'h003F, flc_pkg::OP_BUF_OPEN, 1'b0);
        rreg(flc_pkg::REG_BUF, 32'h10, 32'hFF);
        print_verdict();
    end
endmodule // tb_top
